/* File: common/rbs_map.svh */
// register offsets, field positions, reset values and timing counts of the sequencer
`ifndef RBS_MAP_SVH
`define RBS_MAP_SVH
`define RBS_WAIT_ADDR      14'h3FFE
`define RBS_SYS_ADDR       14'h3FFF
`define RBS_WAIT_RST       16'hFFFF
`define RBS_SYS_RST        16'h0000
`define RBS_SP1_MODE_BIT   10
`define RBS_SP0_EN_BIT     11
`define RBS_SP1_EN_BIT     12
`define RBS_MON_ADDR       14'h0800
`define RBS_FLASH_ADDR     14'h2200
`define RBS_STRETCH_TICKS  65536
`endif

/* File: common/rbs_pkg.sv */
// types shared by the reset and boot sequencer
package rbs_pkg;
   typedef enum logic [4:0] {
      RBS_HOLD  = 5'b00001,
      RBS_MON   = 5'b00010,
      RBS_FLASH = 5'b00100,
      RBS_EXT   = 5'b01000,
      RBS_RUN   = 5'b10000
   } rbs_state_t;
   typedef struct packed {
      logic [13:0] addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } rbs_dm_req_t;
   typedef struct packed {
      logic core;
      logic periph;
      logic stack_empty;
      logic irq_mask;
      logic mode_status_clr;
   } rbs_rst_ctl_t;
   typedef struct packed {
      logic       set_code;
      logic       byte_wr;
      logic       byte_erase;
      logic [1:0] sel;
      logic [7:0] data;
   } rbs_nv_cmd_t;
endpackage

/* File: core/rbs_top.sv */
// reset stretching, boot selection, boot-code security, user bytes and control registers
`include "rbs_map.svh"
module rbs_top #(
   parameter int STRETCH_TICKS = `RBS_STRETCH_TICKS
) (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               rst,
   // supply monitor, reset pin and input clock
   input  wire logic               supply_above_rst,
   input  wire logic               supply_above_hyst,
   input  wire logic               reset_pin_n,
   input  wire logic               input_clock_pin,
   input  wire logic               instruction_clock_out_enable,
   output logic                    instruction_clock_out,
   // reset controls to core and peripherals
   output rbs_pkg::rbs_rst_ctl_t   rst_ctl,
   // boot sequence
   output logic [13:0]             fetch_addr,
   output logic                    ext_boot_req,
   input  wire logic               ext_boot_done,
   // programming utility and debugger port
   input  wire logic               ext_req,
   output logic                    ext_grant,
   input  wire rbs_pkg::rbs_nv_cmd_t ext_cmd,
   // user program clearing routines and byte read
   input  wire logic               user_clr_full,
   input  wire logic               user_clr_reg,
   output logic                    flash_erase_req,
   input  wire logic               flash_erase_done,
   output logic                    boot_code,
   input  wire logic [1:0]         user_byte_sel,
   output logic [7:0]              user_byte_rdata,
   // data memory register access
   input  wire rbs_pkg::rbs_dm_req_t dm_req,
   output logic [15:0]             dm_rdata,
   // control register outputs
   output logic                    serial_port_one_mode,
   output logic                    serial_port_zero_en,
   output logic                    serial_port_one_en,
   output logic [15:0]             wait_state
);
   import rbs_pkg::*;

   localparam int CW = $clog2(STRETCH_TICKS);
   localparam logic [CW-1:0] LAST_TICK = CW'(STRETCH_TICKS - 1);

   logic             clk_in_q;
   logic             tick;
   logic             pwr_good_reg;
   logic             hold_cause;
   logic [CW-1:0]    cnt_reg;
   logic             in_rst_reg;
   logic             clk_out_reg;
   rbs_state_t       state_reg;
   logic [13:0]      fetch_reg;
   logic             boot_code_reg;
   logic             erase_pend_reg;
   logic [7:0]       nvb_reg [4];
   logic [7:0]       byte_rd_reg;
   logic [15:0]      wait_reg;
   logic [15:0]      sys_reg;
   logic [15:0]      rdata_reg;
   logic             user_ok;

   ////////////////////////////////////////////////////////////////////////////
   // instruction clock: one tick per input clock edge, so twice its rate
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         clk_in_q    <= 1'b0;
         clk_out_reg <= 1'b0;
      end
      else
      begin
         clk_in_q    <= input_clock_pin;
         clk_out_reg <= tick & instruction_clock_out_enable;
      end
   end

   // a stopped input clock stalls the stretch count, hence the steady-clock demand
   assign tick = clk_in_q ^ input_clock_pin;
   assign instruction_clock_out = clk_out_reg;

   ////////////////////////////////////////////////////////////////////////////
   // supply monitor with hysteresis: good above threshold, bad below the lower level
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         pwr_good_reg <= 1'b0;
      else if (supply_above_rst)
         pwr_good_reg <= 1'b1;
      else if (!supply_above_hyst)
         pwr_good_reg <= 1'b0;
   end

   assign hold_cause = !pwr_good_reg || !reset_pin_n;

   ////////////////////////////////////////////////////////////////////////////
   // reset stretch counter; any new cause starts the count over
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg    <= '0;
         in_rst_reg <= 1'b1;
      end
      else if (hold_cause)
      begin
         cnt_reg    <= '0;
         in_rst_reg <= 1'b1;
      end
      else if (in_rst_reg && tick)
      begin
         // release only on an instruction tick so all blocks leave together
         if (cnt_reg == LAST_TICK)
            in_rst_reg <= 1'b0;
         else
            cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // every reset effect is the same held level
   assign rst_ctl = {5{in_rst_reg}};

   ////////////////////////////////////////////////////////////////////////////
   // boot sequence: monitor first, then flash or external device
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= RBS_HOLD;
         fetch_reg <= `RBS_MON_ADDR;
      end
      else if (in_rst_reg)
      begin
         state_reg <= RBS_HOLD;
         fetch_reg <= `RBS_MON_ADDR;
      end
      else
      begin
         case (state_reg)
            RBS_HOLD:
               state_reg <= RBS_MON;
            RBS_MON:
            begin
               if (boot_code_reg)
               begin
                  state_reg <= RBS_FLASH;
                  fetch_reg <= `RBS_FLASH_ADDR;
               end
               else
                  state_reg <= RBS_EXT;
            end
            RBS_EXT:
               if (ext_boot_done)
                  state_reg <= RBS_RUN;
            RBS_FLASH,
            RBS_RUN:
               state_reg <= state_reg;
            default:
               state_reg <= RBS_HOLD;
         endcase
      end
   end

   assign fetch_addr   = fetch_reg;
   assign ext_boot_req = (state_reg == RBS_EXT);

   ////////////////////////////////////////////////////////////////////////////
   // outside access is granted only while unsecured and out of reset
   assign ext_grant = ext_req && !boot_code_reg && !in_rst_reg;
   assign user_ok   = !in_rst_reg;

   // boot code: set only by the utility, cleared only by user routines
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         boot_code_reg  <= 1'b0;
         erase_pend_reg <= 1'b0;
      end
      else
      begin
         if (ext_grant && ext_cmd.set_code)
            boot_code_reg <= 1'b1;
         else if (erase_pend_reg && flash_erase_done)
            boot_code_reg <= 1'b0;
         else if (user_ok && user_clr_reg)
            boot_code_reg <= 1'b0;
         // full clear waits for the erase, so a secured program never leaks
         if (erase_pend_reg && flash_erase_done)
            erase_pend_reg <= 1'b0;
         else if (user_ok && user_clr_full && boot_code_reg)
            erase_pend_reg <= 1'b1;
      end
   end

   assign flash_erase_req = erase_pend_reg;
   assign boot_code       = boot_code_reg;

   ////////////////////////////////////////////////////////////////////////////
   // nonvolatile user bytes, kept through chip resets
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 4; i++)
            nvb_reg[i] <= 8'h00;
         byte_rd_reg <= 8'h00;
      end
      else
      begin
         if (ext_grant && ext_cmd.byte_erase)
         begin
            for (int i = 0; i < 4; i++)
               nvb_reg[i] <= 8'h00;
         end
         else if (ext_grant && ext_cmd.byte_wr)
            nvb_reg[ext_cmd.sel] <= ext_cmd.data;
         byte_rd_reg <= nvb_reg[user_byte_sel];
      end
   end

   assign user_byte_rdata = byte_rd_reg;

   ////////////////////////////////////////////////////////////////////////////
   // control registers; chip reset restores defaults, software must fix wait states
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wait_reg <= `RBS_WAIT_RST;
         sys_reg  <= `RBS_SYS_RST;
      end
      else if (in_rst_reg)
      begin
         wait_reg <= `RBS_WAIT_RST;
         sys_reg  <= `RBS_SYS_RST;
      end
      else if (dm_req.wr)
      begin
         if (dm_req.addr == `RBS_WAIT_ADDR)
            wait_reg <= dm_req.wdata;
         if (dm_req.addr == `RBS_SYS_ADDR)
            sys_reg <= dm_req.wdata;
      end
   end

   // read data registered; other addresses answer zero
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         rdata_reg <= 16'h0000;
      else if (dm_req.rd && dm_req.addr == `RBS_WAIT_ADDR)
         rdata_reg <= wait_reg;
      else if (dm_req.rd && dm_req.addr == `RBS_SYS_ADDR)
         rdata_reg <= sys_reg;
      else
         rdata_reg <= 16'h0000;
   end

   assign dm_rdata             = rdata_reg;
   assign wait_state           = wait_reg;
   assign serial_port_one_mode = sys_reg[`RBS_SP1_MODE_BIT];
   assign serial_port_zero_en  = sys_reg[`RBS_SP0_EN_BIT];
   assign serial_port_one_en   = sys_reg[`RBS_SP1_EN_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // checks
   hold_cause_a: assert property (@(posedge mclk) disable iff (rst)
      hold_cause |=> in_rst_reg && rst_ctl.core && rst_ctl.periph)
      else $error("reset not held while a cause is present");

   stretch_len_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(in_rst_reg) |-> $past(cnt_reg) == LAST_TICK && $past(tick))
      else $error("reset released before full stretch or off a tick");

   pwr_down_a: assert property (@(posedge mclk) disable iff (rst)
      !supply_above_hyst && !supply_above_rst |=> !pwr_good_reg ##1 in_rst_reg)
      else $error("low supply did not reassert reset");

   restart_a: assert property (@(posedge mclk) disable iff (rst)
      !reset_pin_n |=> cnt_reg == '0)
      else $error("stretch count not restarted");

   rst_effects_a: assert property (@(posedge mclk) disable iff (rst)
      in_rst_reg |-> rst_ctl.stack_empty && rst_ctl.irq_mask && rst_ctl.mode_status_clr)
      else $error("reset effects missing");

   flash_boot_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(in_rst_reg) && boot_code_reg && !hold_cause
      |-> fetch_addr == `RBS_MON_ADDR ##2 fetch_addr == `RBS_FLASH_ADDR)
      else $error("secured boot did not go monitor then flash");

   ext_boot_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(in_rst_reg) && !boot_code_reg && !hold_cause ##1 !hold_cause
      |=> ext_boot_req)
      else $error("unsecured boot did not request external device");

   refuse_a: assert property (@(posedge mclk) disable iff (rst)
      boot_code_reg && ext_req |-> !ext_grant ##1 $stable(nvb_reg[0]) && $stable(nvb_reg[1])
         && $stable(nvb_reg[2]) && $stable(nvb_reg[3]))
      else $error("secured device accepted an outside write");

   clear_src_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(boot_code_reg) |-> $past(user_clr_reg && user_ok)
         || $past(erase_pend_reg && flash_erase_done))
      else $error("boot code cleared by a foreign source");

   erase_first_a: assert property (@(posedge mclk) disable iff (rst)
      user_ok && user_clr_full && boot_code_reg && !user_clr_reg && !erase_pend_reg
      |=> flash_erase_req && boot_code_reg)
      else $error("full clear dropped code before erase");

   byte_erase_a: assert property (@(posedge mclk) disable iff (rst)
      ext_grant && ext_cmd.byte_erase |=> nvb_reg[0] == 8'h00 && nvb_reg[3] == 8'h00)
      else $error("user bytes not zero after erase");

   clk_out_a: assert property (@(posedge mclk) disable iff (rst)
      instruction_clock_out_enable && (input_clock_pin != clk_in_q) |=> instruction_clock_out)
      else $error("no instruction clock pulse on input edge");

   sys_ctrl_a: assert property (@(posedge mclk) disable iff (rst)
      dm_req.wr && dm_req.addr == `RBS_SYS_ADDR && !in_rst_reg
      |=> serial_port_zero_en == $past(dm_req.wdata[`RBS_SP0_EN_BIT])
         && serial_port_one_mode == $past(dm_req.wdata[`RBS_SP1_MODE_BIT]))
      else $error("system control bits not applied");

   wait_dflt_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(in_rst_reg) |-> wait_state == `RBS_WAIT_RST)
      else $error("wait states not at default after reset");

   release_c: cover property (@(posedge mclk) disable iff (rst) $fell(in_rst_reg));
   flash_c: cover property (@(posedge mclk) disable iff (rst) state_reg == RBS_FLASH);
   ext_c: cover property (@(posedge mclk) disable iff (rst) ext_boot_req ##1 ext_boot_done);
   erase_c: cover property (@(posedge mclk) disable iff (rst) $fell(erase_pend_reg));

endmodule

/* File: tb/rbs_src_model.sv */
// partner model: supply monitor, external reset pin source and input clock source
module rbs_src_model #(
   parameter int HALF = 4
) (
   // clock and commands from the bench
   input  wire logic       mclk,
   input  wire logic [1:0] lvl,
   input  wire logic       pin_low,
   // pins toward the sequencer
   output logic            supply_above_rst,
   output logic            supply_above_hyst,
   output logic            reset_pin_n,
   output logic            input_clock_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int   ph    = 0;
   logic clk_q = 1'b0;
   // never halted, never retimed, even during reset, so ticks stay evenly spaced
   always @(posedge mclk)
   begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1)
         clk_q <= !clk_q;
   end
   assign input_clock_pin = clk_q;
   // level 2 above threshold, 1 inside hysteresis band, 0 below both
   assign supply_above_rst  = (lvl == 2'h2);
   assign supply_above_hyst = (lvl != 2'h0);
   assign reset_pin_n       = !pin_low;
endmodule

/* File: tb/test_rbs_top.sv */
// self-checking bench of the reset and boot sequencer
`include "rbs_map.svh"
module test_rbs_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rbs_pkg::*;
   localparam int ST = 8;
   logic mclk = 1'b0, rst = 1'b1, pin_low = 1'b0, cke = 1'b0, bdone = 1'b0, ereq = 1'b0;
   logic clf = 1'b0, clr = 1'b0, fdone = 1'b0;
   logic [1:0] lvl = 2'h0, bsel = 2'h0;
   rbs_nv_cmd_t cmd = '0;
   rbs_dm_req_t dm = '0;
   wire logic sar, sah, rpn, icp;
   rbs_rst_ctl_t rc;
   logic [13:0] fa;
   logic ebr, egr, fer, bc, sp1m, sp0e, sp1e, ico;
   logic [7:0] ubr;
   logic [15:0] dmr, ws;
   logic [15:0] rnd = 16'h000D;
   int n_mismatch = 0, samples_checked = 0;
   int mb[4] = '{0, 0, 0, 0};
   bit code_m = 1'b0;
   always #5 mclk = ~mclk;
   rbs_top #(.STRETCH_TICKS(ST)) i_dut (
      .mclk(mclk), .rst(rst), .supply_above_rst(sar), .supply_above_hyst(sah),
      .reset_pin_n(rpn), .input_clock_pin(icp), .instruction_clock_out_enable(cke),
      .instruction_clock_out(ico), .rst_ctl(rc), .fetch_addr(fa), .ext_boot_req(ebr),
      .ext_boot_done(bdone), .ext_req(ereq), .ext_grant(egr), .ext_cmd(cmd),
      .user_clr_full(clf), .user_clr_reg(clr), .flash_erase_req(fer),
      .flash_erase_done(fdone), .boot_code(bc), .user_byte_sel(bsel),
      .user_byte_rdata(ubr), .dm_req(dm), .dm_rdata(dmr), .serial_port_one_mode(sp1m),
      .serial_port_zero_en(sp0e), .serial_port_one_en(sp1e), .wait_state(ws));
   rbs_src_model #(.HALF(4)) i_src (.mclk(mclk), .lvl(lvl), .pin_low(pin_low),
      .supply_above_rst(sar), .supply_above_hyst(sah), .reset_pin_n(rpn),
      .input_clock_pin(icp));
   ////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // one data memory access; read data is looked at in its single valid cycle
   task automatic dm_op(logic [13:0] a, logic w, logic [15:0] d);
      @(posedge mclk);
      dm <= '{a, w, !w, d};
      @(posedge mclk);
      dm <= '0;
      #1;
   endtask
   task automatic ext_op(rbs_nv_cmd_t c);
      @(posedge mclk);
      ereq <= 1'b1;
      cmd <= c;
      @(posedge mclk);
      ereq <= 1'b0;
      cmd <= '0;
      #1;
   endtask
   task automatic rd_byte(int s, int e);
      @(posedge mclk);
      bsel <= 2'(s);
      @(posedge mclk);
      #1;
      chk("user byte", 16'(e), {8'h00, ubr});
   endtask
   // drop every cause, then count input-clock ticks until the core leaves reset
   task automatic release_chk();
      logic p;
      int n;
      n = 0;
      // drop causes just after an input edge, so sync latency never swallows a tick
      @(icp);
      p = icp;
      @(posedge mclk);
      lvl <= 2'h2;
      pin_low <= 1'b0;
      repeat (200)
      begin
         #1;
         if (icp !== p)
            n++;
         p = icp;
         if (rc.core === 1'b0)
            break;
         @(posedge mclk);
      end
      chk("ticks to release", 16'(ST), 16'(n));
      chk("rst_ctl release", 16'h0000, {11'h0, rc});
   endtask
   task automatic boot_chk();
      repeat (3) @(posedge mclk);
      #1;
      chk("fetch", code_m ? 16'h2200 : 16'h0800, {2'b00, fa});
      chk("ext boot", {15'h0, !code_m}, {15'h0, ebr});
      @(posedge mclk);
      bdone <= 1'b1;
      @(posedge mclk);
      bdone <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk("ext boot end", 16'h0000, {15'h0, ebr});
   endtask
   // instruction clock pulses once every input clock edge, only while enabled
   task automatic clk_chk(logic en);
      int n;
      n = 0;
      @(posedge mclk);
      cke <= en;
      repeat (4) @(posedge mclk);
      repeat (40)
      begin
         @(posedge mclk);
         #1;
         if (ico === 1'b1)
            n++;
      end
      chk("clock pulses", en ? 16'd10 : 16'd0, 16'(n));
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (20) @(posedge mclk);
      #1;
      chk("rst_ctl low supply", 16'h001F, {11'h0, rc});
      chk("fetch in reset", 16'h0800, {2'b00, fa});
      release_chk();
      boot_chk();
      dm_op(`RBS_WAIT_ADDR, 1'b0, 16'h0000);
      chk("wait reset", `RBS_WAIT_RST, dmr);
      dm_op(`RBS_SYS_ADDR, 1'b0, 16'h0000);
      chk("sys reset", `RBS_SYS_RST, dmr);
      for (int i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         dm_op(`RBS_SYS_ADDR, 1'b1, rnd);
         chk("sys bits", {13'h0, rnd[12:10]}, {13'h0, sp1e, sp0e, sp1m});
         dm_op(`RBS_SYS_ADDR, 1'b0, 16'h0000);
         chk("sys read", rnd, dmr);
      end
      dm_op(`RBS_WAIT_ADDR, 1'b1, 16'h8000);
      chk("wait value", 16'h8000, ws);
      dm_op(14'h3FFD, 1'b1, 16'hFFFF);
      dm_op(14'h3FFD, 1'b0, 16'h0000);
      chk("unmapped", 16'h0000, dmr);
      for (int s = 0; s < 4; s++)
      begin
         rd_byte(s, 0);
         rnd = lfsr(rnd);
         mb[s] = rnd[7:0];
         ext_op('{1'b0, 1'b1, 1'b0, 2'(s), rnd[7:0]});
         rd_byte(s, mb[s]);
      end
      ext_op('{1'b0, 1'b0, 1'b1, 2'h1, 8'h00});
      mb = '{0, 0, 0, 0};
      rd_byte(1, 0);
      rd_byte(3, 0);
      // refill two bytes so later keep and refuse checks see non-zero contents
      for (int s = 0; s < 4; s += 2)
      begin
         rnd = lfsr(rnd);
         mb[s] = {1'b1, rnd[6:0]};
         ext_op('{1'b0, 1'b1, 1'b0, 2'(s), 8'(mb[s])});
      end
      clk_chk(1'b1);
      clk_chk(1'b0);
      ext_op('{1'b1, 1'b0, 1'b0, 2'h0, 8'h00});
      code_m = 1'b1;
      chk("code set", 16'h0001, {15'h0, bc});
      @(posedge mclk);
      ereq <= 1'b1;
      cmd <= '{1'b0, 1'b1, 1'b0, 2'h0, 8'(~mb[0])};
      #1;
      chk("grant refused", 16'h0000, {15'h0, egr});
      @(posedge mclk);
      ereq <= 1'b0;
      cmd <= '0;
      rd_byte(0, mb[0]);
      // pin reset interrupted mid-count, with a write that must be ignored
      @(posedge mclk);
      pin_low <= 1'b1;
      dm_op(`RBS_SYS_ADDR, 1'b1, 16'hFFFF);
      chk("rst_ctl pin", 16'h001F, {11'h0, rc});
      @(posedge mclk);
      pin_low <= 1'b0;
      repeat (10) @(posedge mclk);
      pin_low <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      release_chk();
      boot_chk();
      dm_op(`RBS_SYS_ADDR, 1'b0, 16'h0000);
      chk("sys after pin", `RBS_SYS_RST, dmr);
      rd_byte(2, mb[2]);
      @(posedge mclk);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      #1;
      code_m = 1'b0;
      chk("reg clear code", 16'h0000, {15'h0, bc});
      chk("reg clear no erase", 16'h0000, {15'h0, fer});
      ext_op('{1'b1, 1'b0, 1'b0, 2'h0, 8'h00});
      @(posedge mclk);
      clf <= 1'b1;
      @(posedge mclk);
      clf <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      chk("erase pending", 16'h0003, {14'h0, fer, bc});
      @(posedge mclk);
      fdone <= 1'b1;
      @(posedge mclk);
      fdone <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk("full clear", 16'h0000, {14'h0, fer, bc});
      // supply inside the hysteresis band keeps running, below it resets
      @(posedge mclk);
      lvl <= 2'h1;
      repeat (10) @(posedge mclk);
      #1;
      chk("hyst band", 16'h0000, {11'h0, rc});
      @(posedge mclk);
      lvl <= 2'h0;
      repeat (3) @(posedge mclk);
      #1;
      chk("brown out", 16'h001F, {11'h0, rc});
      release_chk();
      boot_chk();
      final_report();
   end
   // cut a hang short well past the expected run length
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      final_report();
   end
endmodule
